// ===== core/qt_top.sv
// quad timer with auxiliary gate inputs and an AXI4-Lite register slave
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "qt_params.svh"

module qt_top
  import qt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_clock_in_one,
  input wire logic aux_gate_input_a,
  input wire logic aux_gate_input_b,
  input wire logic port_line_three,
  input wire logic port_line_four,
  output logic [3:0] timer_out,
  output logic [5:0] irq_chan
);

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] tclk_s;
  logic [1:0] aux_s1, aux_s2;
  logic [1:0] line_s1, line_s2;
  logic tick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tclk_s <= 3'h0;
      aux_s1 <= 2'h0;
      aux_s2 <= 2'h0;
      line_s1 <= 2'h0;
      line_s2 <= 2'h0;
    end else begin
      tclk_s <= {tclk_s[1:0], timer_clock_in_one};
      aux_s1 <= {aux_gate_input_b, aux_gate_input_a};
      aux_s2 <= aux_s1;
      line_s1 <= {port_line_four, port_line_three};
      line_s2 <= line_s1;
    end
  end

  // one tick per rising edge of the shared timer clock
  assign tick = tclk_s[1] & ~tclk_s[2];

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] waddr, next_waddr;
  logic [7:0] wbyte, next_wbyte;
  logic wlane, next_wlane;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic do_write, wr_hit;
  logic [7:0] raddr;

  qt_byte_type ctrl_a, ctrl_b, ctrl_cd, edge_sel;
  qt_byte_type next_ctrl_a, next_ctrl_b, next_ctrl_cd, next_edge_sel;
  logic [5:0] irq_en, next_irq_en;
  qt_byte_type main_cnt [4];
  logic [3:0] wr_data, out_clr;

  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign raddr = {s_axi_araddr[7:2], 2'b00};

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_waddr = waddr;
    next_wbyte = wbyte;
    next_wlane = wlane;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    next_ctrl_a = ctrl_a;
    next_ctrl_b = ctrl_b;
    next_ctrl_cd = ctrl_cd;
    next_edge_sel = edge_sel;
    next_irq_en = irq_en;
    wr_data = 4'h0;
    out_clr = 4'h0;
    wr_hit = 1'b1;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_waddr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_wbyte = s_axi_wdata[7:0];
      next_wlane = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      case (waddr)
        `QT_OFS_CTRL_A: begin
          if (wlane) begin
            next_ctrl_a = {4'h0, wbyte[3:0]};
            out_clr[0] = wbyte[`QT_CTRL_OUT_CLR];
          end
        end
        `QT_OFS_CTRL_B: begin
          if (wlane) begin
            next_ctrl_b = {4'h0, wbyte[3:0]};
            out_clr[1] = wbyte[`QT_CTRL_OUT_CLR];
          end
        end
        `QT_OFS_CTRL_CD: begin
          if (wlane) begin
            next_ctrl_cd = {1'b0, wbyte[6:4], 1'b0, wbyte[2:0]};
          end
        end
        `QT_OFS_DATA_A: wr_data[0] = wlane;
        `QT_OFS_DATA_B: wr_data[1] = wlane;
        `QT_OFS_DATA_C: wr_data[2] = wlane;
        `QT_OFS_DATA_D: wr_data[3] = wlane;
        `QT_OFS_EDGE: begin
          if (wlane) begin
            next_edge_sel = wbyte;
          end
        end
        `QT_OFS_IRQ_EN: begin
          if (wlane) begin
            next_irq_en = wbyte[5:0];
          end
        end
        `QT_OFS_STATUS: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
      endcase
      next_bresp = wr_hit ? `QT_RESP_OKAY : `QT_RESP_SLVERR;
    end
    next_awready = ~next_aw_held;
    next_wready = ~next_w_held;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = `QT_RESP_OKAY;
      next_rdata = 32'h0;
      case (raddr)
        `QT_OFS_CTRL_A: next_rdata[7:0] = ctrl_a;
        `QT_OFS_CTRL_B: next_rdata[7:0] = ctrl_b;
        `QT_OFS_CTRL_CD: next_rdata[7:0] = ctrl_cd;
        // counter sampled at the read strobe, not the reload value
        `QT_OFS_DATA_A: next_rdata[7:0] = main_cnt[0];
        `QT_OFS_DATA_B: next_rdata[7:0] = main_cnt[1];
        `QT_OFS_DATA_C: next_rdata[7:0] = main_cnt[2];
        `QT_OFS_DATA_D: next_rdata[7:0] = main_cnt[3];
        `QT_OFS_EDGE: next_rdata[7:0] = edge_sel;
        `QT_OFS_IRQ_EN: next_rdata[5:0] = irq_en;
        `QT_OFS_STATUS: next_rdata[7:0] = {2'b00, line_s2, timer_out};
        default: next_rresp = `QT_RESP_SLVERR;
      endcase
    end
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      waddr <= 8'h00;
      wbyte <= 8'h00;
      wlane <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0;
      ctrl_a <= `QT_RST_BYTE;
      ctrl_b <= `QT_RST_BYTE;
      ctrl_cd <= `QT_RST_BYTE;
      edge_sel <= `QT_RST_BYTE;
      irq_en <= `QT_RST_IRQ_EN;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      waddr <= next_waddr;
      wbyte <= next_wbyte;
      wlane <= next_wlane;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      ctrl_a <= next_ctrl_a;
      ctrl_b <= next_ctrl_b;
      ctrl_cd <= next_ctrl_cd;
      edge_sel <= next_edge_sel;
      irq_en <= next_irq_en;
    end
  end

  // ----------------------------------------------------------------------
  // mode decode and gate inputs
  // ----------------------------------------------------------------------
  logic [3:0] cfg [4];
  qt_mode_type mode [4];
  logic [1:0] chan_lvl, chan_lvl_d, aux_rise, line_evt;
  logic [3:0] gate_ok, ev_pulse, to_pulse;

  // timers C and D never see an event or pulse width code
  assign cfg[0] = ctrl_a[3:0];
  assign cfg[1] = ctrl_b[3:0];
  assign cfg[2] = {1'b0, ctrl_cd[2:0]};
  assign cfg[3] = {1'b0, ctrl_cd[6:4]};

  // bit 0 is the line three channel fed by aux B, bit 1 line four by aux A
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (cfg[k] == `QT_CFG_STOP) begin
        mode[k] = QT_STOP;
      end else if (cfg[k] == `QT_CFG_EVENT) begin
        mode[k] = QT_EVENT;
      end else if (cfg[k][3]) begin
        mode[k] = QT_PULSE;
      end else begin
        mode[k] = QT_DELAY;
      end
    end
    // aux inputs take over the line channels in aux modes
    chan_lvl[0] = (mode[1] == QT_PULSE || mode[1] == QT_EVENT) ?
      aux_s2[1] : line_s2[0];
    chan_lvl[1] = (mode[0] == QT_PULSE || mode[0] == QT_EVENT) ?
      aux_s2[0] : line_s2[1];
    // xnor with the edge bit: rising of this level is the selected edge
    chan_lvl[0] = ~(chan_lvl[0] ^ edge_sel[`QT_EDGE_AUX_B]);
    chan_lvl[1] = ~(chan_lvl[1] ^ edge_sel[`QT_EDGE_AUX_A]);
    aux_rise = chan_lvl & ~chan_lvl_d;
    // pulse width measurement reports the end of the active pulse
    line_evt[0] = (mode[1] == QT_PULSE) ?
      (chan_lvl_d[0] & ~chan_lvl[0]) : aux_rise[0];
    line_evt[1] = (mode[0] == QT_PULSE) ?
      (chan_lvl_d[1] & ~chan_lvl[1]) : aux_rise[1];
    // in aux modes the channel level equals aux active state
    gate_ok = {2'b11, chan_lvl[0], chan_lvl[1]};
    ev_pulse = {2'b00, aux_rise[0], aux_rise[1]};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // idle low lines with clear edge bits read as 1: no false edge at start
      chan_lvl_d <= 2'b11;
      irq_chan <= 6'h00;
    end else begin
      chan_lvl_d <= chan_lvl;
      irq_chan <= {line_evt[1], line_evt[0], to_pulse} & irq_en;
    end
  end

  function automatic qt_byte_type div_of(input logic [2:0] sel);
    case (sel)
      3'h1: div_of = `QT_DIV1;
      3'h2: div_of = `QT_DIV2;
      3'h3: div_of = `QT_DIV3;
      3'h4: div_of = `QT_DIV4;
      3'h5: div_of = `QT_DIV5;
      3'h6: div_of = `QT_DIV6;
      3'h7: div_of = `QT_DIV7;
      default: div_of = `QT_DIV1;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // per-timer prescaler and main counter
  // ----------------------------------------------------------------------
  qt_byte_type pre_cnt [4], next_pre_cnt [4];
  qt_byte_type next_main_cnt [4];
  qt_byte_type data_reg [4], next_data_reg [4];
  logic [3:0] next_out, next_to, cnt_pulse;

  for (genvar i = 0; i < 4; i++) begin : g_tmr
    always_comb begin
      next_pre_cnt[i] = pre_cnt[i];
      next_main_cnt[i] = main_cnt[i];
      next_data_reg[i] = data_reg[i];
      next_out[i] = timer_out[i];
      next_to[i] = 1'b0;
      cnt_pulse[i] = 1'b0;
      if (mode[i] == QT_STOP) begin
        next_pre_cnt[i] = 8'h00;
      end else if (mode[i] == QT_EVENT) begin
        cnt_pulse[i] = ev_pulse[i];
      end else if (tick && (mode[i] == QT_DELAY || gate_ok[i])) begin
        // >= so a smaller new divisor still fires within one period
        if (pre_cnt[i] >= div_of(cfg[i][2:0]) - 8'h01) begin
          next_pre_cnt[i] = 8'h00;
          cnt_pulse[i] = 1'b1;
        end else begin
          next_pre_cnt[i] = pre_cnt[i] + 8'h01;
        end
      end
      if (cnt_pulse[i]) begin
        if (main_cnt[i] == 8'h01) begin
          next_main_cnt[i] = data_reg[i];
          next_to[i] = 1'b1;
          next_out[i] = ~timer_out[i];
        end else begin
          // 00 wraps to ff, giving 256 pulses per time-out
          next_main_cnt[i] = main_cnt[i] - 8'h01;
        end
      end
      if (wr_data[i]) begin
        next_data_reg[i] = wbyte;
        if (mode[i] == QT_STOP) begin
          next_main_cnt[i] = wbyte;
        end
      end
      if (out_clr[i]) begin
        next_out[i] = 1'b0;
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pre_cnt[i] <= 8'h00;
        main_cnt[i] <= 8'h00;
        data_reg[i] <= 8'h00;
        timer_out[i] <= 1'b0;
        to_pulse[i] <= 1'b0;
      end else begin
        pre_cnt[i] <= next_pre_cnt[i];
        main_cnt[i] <= next_main_cnt[i];
        data_reg[i] <= next_data_reg[i];
        timer_out[i] <= next_out[i];
        to_pulse[i] <= next_to[i];
      end
    end
  end

endmodule

// ===== core/qt_params.svh
// constants for the quad timer with auxiliary gate inputs
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`ifndef QT_PARAMS_SVH
`define QT_PARAMS_SVH

// register byte offsets
`define QT_OFS_CTRL_A 8'h00
`define QT_OFS_CTRL_B 8'h04
`define QT_OFS_CTRL_CD 8'h08
`define QT_OFS_DATA_A 8'h0c
`define QT_OFS_DATA_B 8'h10
`define QT_OFS_DATA_C 8'h14
`define QT_OFS_DATA_D 8'h18
`define QT_OFS_EDGE 8'h1c
`define QT_OFS_IRQ_EN 8'h20
`define QT_OFS_STATUS 8'h24

// field positions
`define QT_CTRL_OUT_CLR 4
`define QT_EDGE_AUX_A 4
`define QT_EDGE_AUX_B 3

// mode field codes for timers A and B
`define QT_CFG_STOP 4'h0
`define QT_CFG_EVENT 4'h8

// prescale divisors, index 1..7
`define QT_DIV1 8'h04
`define QT_DIV2 8'h0a
`define QT_DIV3 8'h10
`define QT_DIV4 8'h32
`define QT_DIV5 8'h40
`define QT_DIV6 8'h64
`define QT_DIV7 8'hc8

// reset values
`define QT_RST_BYTE 8'h00
`define QT_RST_IRQ_EN 6'h00

// answers
`define QT_RESP_OKAY 2'b00
`define QT_RESP_SLVERR 2'b10

`endif

// ===== core/qt_pkg.sv
// types for the quad timer with auxiliary gate inputs
package qt_pkg;

  typedef enum logic [1:0] {
    QT_STOP = 2'b00,
    QT_DELAY = 2'b01,
    QT_EVENT = 2'b10,
    QT_PULSE = 2'b11
  } qt_mode_type;

  typedef logic [7:0] qt_byte_type;

endpackage

// ===== dv/qt_far_end.sv
// far-side model: timer oscillator and external gate and port line sources
`timescale 1ns/1ns
module qt_far_end (
  input wire logic clk,
  input wire logic [3:0] level_req,
  output logic timer_clock_in_one,
  output logic [3:0] lines
);
  logic [1:0] div = 2'b00;
  // --------------------------------
  // oscillator
  // --------------------------------
  // runs free, one rising edge per four system clocks: below clk/2 as needed
  always @(posedge clk) begin
    div <= div + 2'b01;
  end
  assign timer_clock_in_one = div[1];
  // gate sources change only when the host asks, far slower than the ticks
  assign lines = level_req;
endmodule

// ===== dv/qt_top_properties.sv
// port assertions for the quad timer
`timescale 1ns/1ns
module qt_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] timer_out,
  input wire logic [5:0] irq_chan
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      !s_axi_bvalid;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (
    wr_taken |-> ##2 s_axi_bvalid) else $error("write not answered");
  rd_answer_a: assert property (
    rd_taken |=> s_axi_rvalid) else $error("read not answered");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  r_byte_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("wide data");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  irq_single_a: assert property (
    |irq_chan[3:0] |=> (irq_chan[3:0] & $past(irq_chan[3:0])) == 4'h0)
    else $error("timeout pulse too long");
  irq_toggle_a: assert property (
    (irq_chan[3:0] & ~($past(timer_out) ^ $past(timer_out, 2))) == 4'h0)
    else $error("timeout without toggle");
  reset_low_a: assert property (
    $rose(rst_n) |-> timer_out == 4'h0 && irq_chan == 6'h0)
    else $error("outputs not low after reset");
endmodule

bind qt_top qt_checker qt_checker_i (.clk, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .timer_out, .irq_chan);

// ===== dv/qt_top_test.sv
// self-checking bench for the quad timer
`timescale 1ns/1ns
`include "qt_params.svh"
module qt_top_test;
  localparam logic [1:0] OK = `QT_RESP_OKAY;
  localparam logic [1:0] SE = `QT_RESP_SLVERR;
  localparam int DIV[8] = '{0, 4, 10, 16, 50, 64, 100, 200};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] lvl = 4'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tclk;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] tout, lines;
  logic [5:0] irq;
  logic [7:0] r;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  int num_errors = 0;
  int compares = 0;
  int nirq[6] = '{default: 0};
  int b0, b5;

  always #4 clk = ~clk;

  qt_far_end qt_far_end_i (.clk(clk), .level_req(lvl),
    .timer_clock_in_one(tclk), .lines(lines));
  qt_top qt_top_i (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_clock_in_one(tclk), .aux_gate_input_a(lines[0]),
    .aux_gate_input_b(lines[1]), .port_line_three(lines[2]),
    .port_line_four(lines[3]), .timer_out(tout), .irq_chan(irq));

  // --------------------------------
  // checks and bus tasks
  // --------------------------------
  task automatic chk(input string nm, input logic [33:0] e,
                     input logic [33:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] e);
    int n;
    logic ad, wd, bd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    bd = 1'b0;
    exp_b.push_back(e);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // local flags: the driven signals only update after this time step
    while (!(ad && wd && bd) && n < 99) begin
      @(posedge clk);
      n++;
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
      if (!bd && bvalid === 1'b1) begin
        bd = 1'b1;
        bready <= 1'b0;
      end
    end
    chk("wr_done", 34'h1, {33'h0, bd});
    // one idle edge so a following call never re-raises bready at once
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] e);
    int n;
    logic ad, rv;
    n = 0;
    ad = 1'b0;
    rv = 1'b0;
    exp_r.push_back({e, 24'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!(ad && rv) && n < 99) begin
      @(posedge clk);
      n++;
      if (!ad && arready === 1'b1) begin
        ad = 1'b1;
        arvalid <= 1'b0;
      end
      if (!rv && rvalid === 1'b1) begin
        rv = 1'b1;
        rready <= 1'b0;
      end
    end
    chk("rd_done", 34'h1, {33'h0, rv});
    @(posedge clk);
  endtask

  // skips two pulses so a prescaler change has settled, then times one gap
  task automatic gap(input int b, input int e);
    int n;
    int t;
    n = 0;
    t = 0;
    repeat (2) begin
      while (irq[b] !== 1'b1 && t < 20000) begin
        @(posedge clk);
        t++;
      end
      @(posedge clk);
    end
    while (irq[b] !== 1'b1 && t < 20000) begin
      @(posedge clk);
      n++;
      t++;
    end
    chk("gap", e, n + 1);
  endtask

  always @(posedge clk) begin
    if (bvalid === 1'b1 && bready) chk("bresp", exp_b.pop_front(), bresp);
    if (rvalid === 1'b1 && rready) chk("rdata", exp_r.pop_front(),
                                       {rresp, rdata});
    for (int i = 0; i < 6; i++) begin
      if (irq[i] === 1'b1) nirq[i] <= nirq[i] + 1;
    end
  end

  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    // the tests need about 24000 cycles
    repeat (60000) @(posedge clk);
    num_errors++;
    summarize;
  end

  // --------------------------------
  // tests
  // --------------------------------
  initial begin
    void'($urandom(44));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 11; a++) begin
      rd(8'(a * 4), 8'h00, a == 10 ? SE : OK);
    end
    wr(8'h3c, 8'h5a, SE);
    $display("test reset done");
    r = 8'($urandom_range(255, 1));
    wr(`QT_OFS_DATA_D, r, OK);
    rd(`QT_OFS_DATA_D, r, OK);
    wstrb <= 4'he;
    wr(`QT_OFS_DATA_D, ~r, OK);
    wstrb <= 4'hf;
    rd(`QT_OFS_DATA_D, r, OK);
    $display("test load done");
    wr(`QT_OFS_DATA_C, 8'h01, OK);
    wr(`QT_OFS_IRQ_EN, 8'h0c, OK);
    for (int s = 1; s < 8; s++) begin
      wr(`QT_OFS_CTRL_CD, 8'(s), OK);
      gap(2, 4 * DIV[s]);
    end
    wr(`QT_OFS_DATA_D, 8'h00, OK);
    wr(`QT_OFS_CTRL_CD, 8'h11, OK);
    gap(3, 4096);
    wr(`QT_OFS_IRQ_EN, 8'h04, OK);
    b0 = nirq[3];
    repeat (4200) @(posedge clk);
    chk("masked", b0, nirq[3]);
    wr(`QT_OFS_CTRL_CD, 8'h00, OK);
    repeat (4) @(posedge clk);
    chk("tout_c", nirq[2] % 2, tout[2]);
    $display("test delay done");
    for (int e = 0; e < 2; e++) begin
      wr(`QT_OFS_IRQ_EN, 8'h00, OK);
      lvl <= e ? 4'h0 : 4'hc;
      repeat (8) @(posedge clk);
      wr(`QT_OFS_EDGE, e ? 8'h18 : 8'h00, OK);
      wr(`QT_OFS_IRQ_EN, 8'h30, OK);
      b0 = nirq[4] + nirq[5];
      lvl <= e ? 4'hc : 4'h0;
      repeat (20) @(posedge clk);
      lvl <= e ? 4'h0 : 4'hc;
      repeat (20) @(posedge clk);
      chk("line_irq", b0 + 2, nirq[4] + nirq[5]);
    end
    $display("test lines done");
    for (int e = 0; e < 2; e++) begin
      wr(`QT_OFS_IRQ_EN, 8'h00, OK);
      lvl <= e ? 4'h0 : 4'h1;
      repeat (8) @(posedge clk);
      wr(`QT_OFS_EDGE, e ? 8'h10 : 8'h00, OK);
      wr(`QT_OFS_DATA_A, 8'h01, OK);
      wr(`QT_OFS_CTRL_A, 8'h09, OK);
      wr(`QT_OFS_IRQ_EN, 8'h21, OK);
      b0 = nirq[0];
      b5 = nirq[5];
      repeat (200) @(posedge clk);
      chk("pw_idle", b0, nirq[0]);
      lvl <= e ? 4'h1 : 4'h0;
      repeat (320) @(posedge clk);
      lvl <= e ? 4'h0 : 4'h1;
      repeat (40) @(posedge clk);
      chk("pw_run", 1, nirq[0] - b0 inside {[19:21]});
      chk("pw_end", b5 + 1, nirq[5]);
      wr(`QT_OFS_CTRL_A, 8'h00, OK);
    end
    repeat (4) @(posedge clk);
    chk("tout_a", nirq[0] % 2, tout[0]);
    $display("test pulse done");
    wr(`QT_OFS_IRQ_EN, 8'h00, OK);
    wr(`QT_OFS_EDGE, 8'h08, OK);
    wr(`QT_OFS_DATA_B, 8'h03, OK);
    wr(`QT_OFS_CTRL_B, 8'h08, OK);
    wr(`QT_OFS_IRQ_EN, 8'h02, OK);
    b0 = nirq[1];
    repeat (6) begin
      lvl <= lvl ^ 4'h2;
      repeat (20) @(posedge clk);
    end
    chk("event", b0 + 1, nirq[1]);
    chk("tout_b", 1, tout[1]);
    wr(`QT_OFS_CTRL_B, 8'h00, OK);
    $display("test event done");
    summarize;
  end
endmodule
